// File: design/mfs_params.svh
// constants of the multi-function light switch
`ifndef MFS_PARAMS_SVH
`define MFS_PARAMS_SVH
`define MFS_TIME_W   16
`define MFS_BLK_W    4
`define MFS_NUM_BLK  16
`define MFS_NUM_PAR  4
`define MFS_PAR_OFF  0
`define MFS_PAR_PERM 1
`define MFS_PAR_LEAD 2
`define MFS_PAR_LEN  3
`define MFS_CLK_NS   10
`define MFS_TICK_NS  10000000
`define MFS_TICK_CYCLES (`MFS_TICK_NS / `MFS_CLK_NS)
`endif

// File: design/mfs_pkg.sv
// types of the multi-function light switch
package mfs_pkg;
	typedef enum logic [2:0] {
		MFS_ST_RESTORE,
		MFS_ST_IDLE,
		MFS_ST_HELD,
		MFS_ST_DELAY,
		MFS_ST_PERM
	} mfs_state_t;
endpackage

// File: design/mfs_par_if.sv
// resolved time parameters passed from source selector to the switch core
`include "mfs_params.svh"
interface mfs_par_if #(
	parameter int TW = `MFS_TIME_W
);
	logic [TW-1:0] t [`MFS_NUM_PAR];
	modport src (output t);
	modport use_p (input t);
endinterface

// File: design/mfs_time_src.sv
// time parameter source selector: stored constant or live value of another block
`include "mfs_params.svh"
module mfs_time_src #(
	parameter int TW   = `MFS_TIME_W,
	parameter int BW   = `MFS_BLK_W,
	parameter int NBLK = `MFS_NUM_BLK
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [TW-1:0] const_val [`MFS_NUM_PAR],
	input  wire logic          use_live  [`MFS_NUM_PAR],
	input  wire logic [BW-1:0] blk_sel   [`MFS_NUM_PAR],
	input  wire logic [TW-1:0] live_val  [NBLK],
	mfs_par_if.src             par
);
	// =====================================
	// per-parameter selection
	genvar i;
	generate
		for (i = 0; i < `MFS_NUM_PAR; i++) begin : g_par
			logic [TW-1:0] val_reg;
			logic [TW-1:0] val_next;
			always_comb begin
				val_next = const_val[i];
				if (use_live[i]) begin
					// out-of-range block number reads as zero
					if (32'(blk_sel[i]) < NBLK) begin
						val_next = live_val[blk_sel[i]];
					end else begin
						val_next = '0;
					end
				end
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					val_reg <= '0;
				end else begin
					val_reg <= val_next;
				end
			end
			assign par.t[i] = val_reg;
		end
	endgenerate
endmodule

// File: design/mfs_switch.sv
// multi-function light switch core: off-delay, permanent light, pre-warning
`include "mfs_params.svh"

module mfs_switch #(
	parameter int TW          = `MFS_TIME_W,
	parameter int BW          = `MFS_BLK_W,
	parameter int NBLK        = `MFS_NUM_BLK,
	parameter int TICK_CYCLES = `MFS_TICK_CYCLES
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          trg,
	input  wire logic          timer_reset,
	input  wire logic          retentive,
	input  wire logic          restore_q,
	input  wire logic          restore_perm,
	input  wire logic [TW-1:0] restore_elapsed,
	input  wire logic [TW-1:0] const_val [`MFS_NUM_PAR],
	input  wire logic          use_live  [`MFS_NUM_PAR],
	input  wire logic [BW-1:0] blk_sel   [`MFS_NUM_PAR],
	input  wire logic [TW-1:0] live_val  [NBLK],
	output logic               q,
	output logic [TW-1:0]      elapsed_time,
	output logic               perm_active,
	output logic               timing_active
);
	localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

	// =====================================
	// parameter sources
	mfs_par_if #(.TW(TW)) par ();

	mfs_time_src #(
		.TW   (TW),
		.BW   (BW),
		.NBLK (NBLK)
	) u_src (
		.clk       (clk),
		.rst       (rst),
		.const_val (const_val),
		.use_live  (use_live),
		.blk_sel   (blk_sel),
		.live_val  (live_val),
		.par       (par)
	);

	logic [TW-1:0] off_delay;
	logic [TW-1:0] perm_time;
	logic [TW-1:0] warn_lead;
	logic [TW-1:0] warn_len;

	// one timebase: all four counted in the same tick units
	assign off_delay = par.t[`MFS_PAR_OFF];
	assign perm_time = par.t[`MFS_PAR_PERM];
	assign warn_lead = par.t[`MFS_PAR_LEAD];
	assign warn_len  = par.t[`MFS_PAR_LEN];

	// =====================================
	// timebase tick
	logic [CW-1:0] tick_cnt_reg;
	logic [CW-1:0] tick_cnt_next;
	logic          tick;

	always_comb begin
		tick = (tick_cnt_reg == TICK_LAST);
		if (tick) begin
			tick_cnt_next = '0;
		end else begin
			tick_cnt_next = tick_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
		end
	end

	// =====================================
	// pre-warning window
	logic [TW-1:0] elapsed_reg;
	logic [TW-1:0] elapsed_next;
	logic [TW-1:0] win_start;
	logic [TW:0]   win_end;
	logic          in_warn;

	always_comb begin
		// lead longer than the delay starts the warning at once
		if (warn_lead > off_delay) begin
			win_start = '0;
		end else begin
			win_start = off_delay - warn_lead;
		end
		win_end = {1'b0, win_start} + {1'b0, warn_len};
		in_warn = (warn_len != '0) &&
			(elapsed_reg >= win_start) &&
			({1'b0, elapsed_reg} < win_end);
	end

	// =====================================
	// switch state
	mfs_pkg::mfs_state_t state_reg;
	mfs_pkg::mfs_state_t state_next;
	logic [TW-1:0]       hold_reg;
	logic [TW-1:0]       hold_next;
	logic                trg_d_reg;
	logic                trg_d_next;
	logic                q_reg;
	logic                q_next;
	logic                rise;

	always_comb begin
		rise         = trg && !trg_d_reg;
		state_next   = state_reg;
		elapsed_next = elapsed_reg;
		hold_next    = hold_reg;
		trg_d_next   = trg;
		q_next       = q_reg;
		case (state_reg)
			mfs_pkg::MFS_ST_RESTORE: begin
				// current trigger level taken as old level, so no false edge
				hold_next = '0;
				if (retentive && restore_q && restore_perm) begin
					state_next   = mfs_pkg::MFS_ST_PERM;
					elapsed_next = restore_elapsed;
					q_next       = 1'b1;
				end else if (retentive && restore_q) begin
					state_next   = mfs_pkg::MFS_ST_DELAY;
					elapsed_next = restore_elapsed;
					q_next       = 1'b1;
				end else if (retentive) begin
					state_next   = mfs_pkg::MFS_ST_IDLE;
					elapsed_next = restore_elapsed;
					q_next       = 1'b0;
				end else begin
					state_next   = mfs_pkg::MFS_ST_IDLE;
					elapsed_next = '0;
					q_next       = 1'b0;
				end
			end
			mfs_pkg::MFS_ST_IDLE: begin
				if (rise) begin
					state_next   = mfs_pkg::MFS_ST_HELD;
					elapsed_next = '0;
					hold_next    = '0;
					q_next       = 1'b1;
				end
			end
			mfs_pkg::MFS_ST_HELD: begin
				q_next = 1'b1;
				if (!trg) begin
					state_next   = mfs_pkg::MFS_ST_DELAY;
					elapsed_next = '0;
				end else if (hold_reg >= perm_time) begin
					state_next = mfs_pkg::MFS_ST_PERM;
				end else if (tick) begin
					hold_next = hold_reg + 1'b1;
				end
			end
			mfs_pkg::MFS_ST_DELAY: begin
				if (rise) begin
					state_next   = mfs_pkg::MFS_ST_IDLE;
					elapsed_next = '0;
					q_next       = 1'b0;
				end else if (elapsed_reg >= off_delay) begin
					// restored or live values past the delay also expire
					state_next = mfs_pkg::MFS_ST_IDLE;
					q_next     = 1'b0;
				end else begin
					q_next = !in_warn;
					if (tick) begin
						elapsed_next = elapsed_reg + 1'b1;
					end
				end
			end
			mfs_pkg::MFS_ST_PERM: begin
				q_next = 1'b1;
				if (rise) begin
					state_next   = mfs_pkg::MFS_ST_IDLE;
					elapsed_next = '0;
					q_next       = 1'b0;
				end
			end
			default: begin
				state_next   = mfs_pkg::MFS_ST_IDLE;
				elapsed_next = '0;
				q_next       = 1'b0;
			end
		endcase
		// reset input overrides everything outside the restore state, trigger edges included
		if (timer_reset && state_reg != mfs_pkg::MFS_ST_RESTORE) begin
			state_next   = mfs_pkg::MFS_ST_IDLE;
			elapsed_next = '0;
			hold_next    = '0;
			q_next       = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg   <= mfs_pkg::MFS_ST_RESTORE;
			elapsed_reg <= '0;
			hold_reg    <= '0;
			trg_d_reg   <= 1'b0;
			q_reg       <= 1'b0;
		end else begin
			state_reg   <= state_next;
			elapsed_reg <= elapsed_next;
			hold_reg    <= hold_next;
			trg_d_reg   <= trg_d_next;
			q_reg       <= q_next;
		end
	end

	// =====================================
	// outputs
	logic perm_reg;
	logic perm_next;
	logic timing_reg;
	logic timing_next;

	always_comb begin
		perm_next   = (state_next == mfs_pkg::MFS_ST_PERM);
		timing_next = (state_next == mfs_pkg::MFS_ST_DELAY);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			perm_reg   <= 1'b0;
			timing_reg <= 1'b0;
		end else begin
			perm_reg   <= perm_next;
			timing_reg <= timing_next;
		end
	end

	assign q             = q_reg;
	assign elapsed_time  = elapsed_reg;
	assign perm_active   = perm_reg;
	assign timing_active = timing_reg;
endmodule

// File: bench/mfs_switch_properties.sv
// port assertions of the light switch core
`include "mfs_params.svh"
module mfs_switch_properties #(
	parameter int TW = `MFS_TIME_W
) (
	input wire logic          clk,
	input wire logic          rst,
	input wire logic          trg,
	input wire logic          timer_reset,
	input wire logic          retentive,
	input wire logic          restore_q,
	input wire logic [TW-1:0] restore_elapsed,
	input wire logic [TW-1:0] const_val [`MFS_NUM_PAR],
	input wire logic          use_live  [`MFS_NUM_PAR],
	input wire logic          q,
	input wire logic [TW-1:0] elapsed_time,
	input wire logic          perm_active,
	input wire logic          timing_active
);
	// ===========================
	// edges since reset release
	logic [1:0] run_reg;
	logic [1:0] run_next;
	always_comb begin
		run_next = {run_reg[0], 1'b1};
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_reg <= 2'h0;
		end else begin
			run_reg <= run_next;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ===========================
	// assertions
	reset_clears_a: assert property (run_reg[1] && timer_reset |=> !q && elapsed_time == '0)
		else $error("timer reset ignored");
	reset_wins_a: assert property (run_reg[1] && timer_reset && $rose(trg) |=> !q && !perm_active)
		else $error("trigger beat reset");
	rise_on_a: assert property (run_reg[1] && $rose(trg) && !timer_reset && !q && !perm_active
		&& !timing_active |=> q)
		else $error("rise left q low");
	retrig_off_a: assert property (run_reg[1] && $rose(trg) && !timer_reset && (perm_active || timing_active)
		|=> !q && elapsed_time == '0 && !perm_active && !timing_active)
		else $error("retrigger not cleared");
	perm_hold_a: assert property (perm_active && !timer_reset && !$rose(trg) |=> perm_active && q)
		else $error("permanent light lost");
	perm_entry_a: assert property (run_reg[1] && $rose(perm_active) |-> q && $past(trg) && !timing_active)
		else $error("bad permanent entry");
	delay_start_a: assert property ($past(run_reg[1]) && $rose(timing_active)
		|-> elapsed_time == '0 && !$past(trg))
		else $error("delay start wrong");
	delay_end_a: assert property (run_reg[1] && timing_active && !timer_reset && !$rose(trg)
		&& !$past(use_live[0]) && elapsed_time == $past(const_val[0]) |=> !q && !timing_active)
		else $error("no off at expiry");
	restore_a: assert property ($rose(run_reg[0]) |-> q == ($past(retentive) && $past(restore_q))
		&& elapsed_time == ($past(retentive) ? $past(restore_elapsed) : '0))
		else $error("bad restore");
endmodule
bind mfs_switch mfs_switch_properties #(.TW(TW)) mfs_switch_properties_inst (.clk, .rst, .trg, .timer_reset,
	.retentive, .restore_q, .restore_elapsed, .const_val, .use_live, .q, .elapsed_time, .perm_active,
	.timing_active);

// File: bench/mfs_lines.sv
// trigger and reset lines of the far side
module mfs_lines (
	input  wire logic clk,
	output logic      trg,
	output logic      timer_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		trg = 1'b0;
		timer_reset = 1'b0;
	end
	// lines move just after a rising edge
	task automatic set(input logic t, input logic r);
		@(posedge clk);
		trg <= t;
		timer_reset <= r;
		// callers read outputs settled after the edge
		#1;
	endtask
endmodule

// File: bench/tb_multi_function_light_switch.sv
// self-checking bench of the light switch core
`include "mfs_params.svh"
module tb_multi_function_light_switch;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TW = `MFS_TIME_W;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          trg;
	logic          timer_reset;
	logic          retentive = 1'b0;
	logic          restore_q = 1'b0;
	logic          restore_perm = 1'b0;
	logic [TW-1:0] restore_elapsed = 16'h0;
	logic [TW-1:0] const_val [4] = '{16'h5, 16'h0, 16'h2, 16'h1};
	logic          use_live [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic [3:0]    blk_sel [4] = '{4'h0, 4'h3, 4'hF, 4'h0};
	logic [TW-1:0] live_val [16] = '{3: 16'h3, default: 16'h0};
	logic          q;
	logic [TW-1:0] elapsed_time;
	logic          perm_active;
	logic          timing_active;
	int            mismatches = 0;
	int            tests_run = 0;
	int            cycles = 0;
	int            n;
	int            lo;
	always #5 clk = ~clk;
	mfs_lines mfs_lines_inst (.clk, .trg, .timer_reset);
	mfs_switch #(.TICK_CYCLES(4)) mfs_switch_inst (.clk, .rst, .trg, .timer_reset, .retentive, .restore_q,
		.restore_perm, .restore_elapsed, .const_val, .use_live, .blk_sel, .live_val, .q, .elapsed_time,
		.perm_active, .timing_active);
	// ===========================
	// tasks
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [TW-1:0] got, input logic [TW-1:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic wq(input logic v, input string m);
		for (int i = 0; i < 3 && q !== v; i++) cyc(1);
		chk(q, v, m);
	endtask
	task automatic pulse();
		mfs_lines_inst.set(1'b1, 1'b0);
		mfs_lines_inst.set(1'b0, 1'b0);
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			print_verdict();
		end
	end
	// ===========================
	// tests
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		cyc(3);
		chk(q, 0, "q after power up");
		// hold shorter than the live permanent time, then off-delay with warning
		mfs_lines_inst.set(1'b1, 1'b0);
		cyc(2);
		mfs_lines_inst.set(1'b0, 1'b0);
		chk(q, 1, "no switch on");
		lo = 0;
		n = 0;
		for (int i = 0; i < 40; i++) begin
			cyc(1);
			lo += (timing_active === 1'b1 && q === 1'b0);
			n += (timing_active === 1'b1);
		end
		chk(perm_active, 0, "permanent too early");
		chk(TW'(lo), 4, "warning length");
		chk(TW'(n >= 17 && n <= 22), 1, "delay length");
		chk(q, 0, "q after delay");
		pulse();
		cyc(4);
		pulse();
		wq(1'b0, "retrigger kept q");
		cyc(30);
		chk(q, 0, "retrigger restarted");
		pulse();
		cyc(4);
		mfs_lines_inst.set(1'b0, 1'b1);
		mfs_lines_inst.set(1'b0, 1'b0);
		wq(1'b0, "reset kept q");
		chk(elapsed_time, 0, "reset kept time");
		mfs_lines_inst.set(1'b1, 1'b1);
		mfs_lines_inst.set(1'b0, 1'b0);
		cyc(2);
		chk(q, 0, "trigger beat reset");
		mfs_lines_inst.set(1'b1, 1'b0);
		cyc(20);
		chk(perm_active, 1, "no permanent light");
		mfs_lines_inst.set(1'b0, 1'b0);
		cyc(40);
		chk(q, 1, "permanent light ended");
		pulse();
		wq(1'b0, "permanent not cleared");
		@(posedge clk);
		retentive <= 1'b1;
		restore_q <= 1'b1;
		restore_elapsed <= 16'h2;
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		cyc(2);
		chk(q, 1, "q not restored");
		chk(elapsed_time, 16'h2, "time not restored");
		mfs_lines_inst.set(1'b0, 1'b1);
		mfs_lines_inst.set(1'b0, 1'b0);
		wq(1'b0, "reset kept restored q");
		// power return into permanent light
		@(posedge clk);
		restore_perm <= 1'b1;
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		cyc(3);
		chk(perm_active, 1, "permanent not restored");
		chk(q, 1, "permanent q not restored");
		print_verdict();
	end
endmodule
